// File: pkg/fpf_defs.vh
// constants and register map of the fixed-point filter sequencer
//
// Contract
// - word: bit15 wait, bits14-12 wake select, event bit, 3-bit opcode, two operands.
// - opcode 0x0 only advances the program counter by one.
// - jump loads the program counter with the 5-bit operand target.
// - multiply puts signed product in acc[31:0], sign in acc[35:32].
// - multiply-accumulate adds sign-extended product, saturating to 0x7FFFFFFFF or 0x800000000.
// - divide: 16-bit reciprocal of divisor times dividend into acc; only multi-cycle op.
// - shift-left-load puts register shifted left into acc, sign-filled above, zeros below.
// - shift-right-store shifts acc right, rounds, saturates to 16 bits, writes register.
// - chain move shifts registers up one step; lower register keeps its value.
// - chain move with upper index not above lower index is a no-operation.
// - sequencing starts instructions only while unit enabled, from the preset program counter.
// - waiting instruction halts until its selected low register is written.
// - writes set written flag; waiting instruction consumes it, clearing it.
// - after address 0x1F the program counter wraps to 0x0.
// - finished event instruction sets event flag, pulses event, interrupts if enabled.
// - event goes to second output when wake field is 7, else first.
// - wait plus event: the event follows only after resuming.
// - sticky alu and shifter saturation flags, cleared by software.
// - in step mode one instruction runs per step pulse write.
// - no step when mode and pulse set together; step ignores wait and wraps.
// - external access wins contention; the sequencer stalls.
// - 16-bit registers: low write held, high write commits; reads latch high half.
// - cpu has two access counters, mover one; the two cpu counters share one clear bit, mover has its own.
// - instruction store is 32x16 at address register, low then high byte.
`ifndef FPF_DEFS_VH
`define FPF_DEFS_VH
`define FPF_A_CTRL   8'h00
`define FPF_A_PC     8'h01
`define FPF_A_TRIG   8'h02
`define FPF_A_CLR    8'h03
`define FPF_A_DBG    8'h04
`define FPF_A_RF_HI  4'h1
`define FPF_A_ACC0   8'h20
`define FPF_A_ACC4   8'h24
`define FPF_A_PRGL   8'h28
`define FPF_A_PRGH   8'h29
`define FPF_A_PRGA   8'h2A
`define FPF_B_EN     7
`define FPF_B_IE     6
`define FPF_B_SS     2
`define FPF_B_SA     1
`define FPF_B_EVF    0
`define FPF_B_MODE   7
`define FPF_B_STEP   6
`define FPF_B_CCLR   1
`define FPF_B_MCLR   0
`define FPF_OP_NOP   3'h0
`define FPF_OP_JMP   3'h1
`define FPF_OP_MUL   3'h2
`define FPF_OP_MAC   3'h3
`define FPF_OP_DIV   3'h4
`define FPF_OP_LSF   3'h5
`define FPF_OP_RSF   3'h6
`define FPF_OP_MVC   3'h7
`define FPF_DIV_CYC  4'h8
`define FPF_SAT_POS  36'h7FFFFFFFF
`define FPF_SAT_NEG  36'h800000000
`define FPF_RCP_ONE  32'h00008000
`define FPF_RCP_MAX  16'h7FFF
`endif

// File: hw/fpf_top.v
// fixed-point filter sequencer: store, register file, datapath, sequencer, register port
//
// Chosen here: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "fpf_defs.vh"
module fpf_top (
  input  wire       ref_clk,   // system clock
  input  wire       rst_n,     // async reset, low
  input  wire [7:0] cpu_addr,  // cpu register address
  input  wire [7:0] cpu_wdata, // cpu write data
  input  wire       cpu_wr,    // cpu write strobe
  input  wire       cpu_rd,    // cpu read strobe
  output reg  [7:0] cpu_rdata, // cpu read data, cycle after strobe
  input  wire [2:0] mov_addr,  // mover register select r0..r7
  input  wire [7:0] mov_wdata, // mover write data
  input  wire       mov_wr,    // mover write strobe
  input  wire       mov_rd,    // mover read strobe
  output reg  [7:0] mov_rdata, // mover read data, cycle after strobe
  output reg        event0,    // event pulse, first output
  output reg        event1,    // event pulse, second output
  output wire       irq        // interrupt request level
);
  reg        rst_s1_q;
  reg        rst_s2_q;
  reg [15:0] rf_q [0:15];
  reg [15:0] prog_q [0:31];
  reg [35:0] acc_q;
  reg [4:0]  pc_q;
  reg        en_q, ie_q, ss_q, sa_q, evf_q;
  reg [7:0]  trg_q;
  reg        mode_q, stp_q;
  reg [3:0]  div_q;
  reg        cs_cnt_q, cx_cnt_q, mv_cnt_q;
  reg [7:0]  cs_tmp_q, cx_tmp_q, mv_tmp_q;
  reg [4:0]  padr_q;
  reg [7:0]  plo_q;
  integer    i;

  // released reset
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  wire rst_ni = rst_s2_q;

  // external decode
  wire [3:0] c_idx  = cpu_addr[3:0];
  wire       c_rf   = (cpu_addr[7:4] == `FPF_A_RF_HI);
  wire       c_cnt  = c_idx[3] ? cx_cnt_q : cs_cnt_q;
  wire [7:0] c_tmp  = c_idx[3] ? cx_tmp_q : cs_tmp_q;
  wire       c_acc  = (cpu_addr >= `FPF_A_ACC0) && (cpu_addr <= `FPF_A_ACC4);
  wire       c_cmt  = cpu_wr & c_rf & c_cnt;
  wire [3:0] m_idx  = {1'b0, mov_addr};
  wire       m_cmt  = mov_wr & mv_cnt_q & ~(c_cmt & (c_idx == m_idx));
  wire       c_w    = cpu_wr & ~c_rf;
  wire       stall  = cpu_wr | cpu_rd | mov_wr | mov_rd;

  // instruction fields
  wire [15:0] ins = prog_q[pc_q];
  wire        wt  = ins[15];
  wire [2:0]  wk  = ins[14:12];
  wire        ev  = ins[11];
  wire [2:0]  op  = ins[10:8];
  wire [3:0]  fa  = ins[7:4];
  wire [3:0]  fb  = ins[3:0];
  wire [15:0] rm  = rf_q[fa];
  wire [15:0] rn  = rf_q[fb];

  // wait satisfied by a stored write, or forced by a step
  wire hit   = trg_q[wk];
  wire ready = ~wt | hit | mode_q;
  wire busy  = (div_q != 4'h0);
  wire start = en_q & ~stall & ~busy & ready & (~mode_q | stp_q);
  wire done  = (start & (op != `FPF_OP_DIV)) | (busy & ~stall & (div_q == 4'h1));

  // datapath
  wire signed [31:0] prod = $signed(rn) * $signed(rm);
  wire [35:0] prod36 = {{4{prod[31]}}, prod};
  wire [36:0] msum   = {acc_q[35], acc_q} + {prod36[35], prod36};
  wire        movf   = msum[36] ^ msum[35];

  wire [16:0] mag  = rm[15] ? (17'h00000 - {rm[15], rm}) : {1'b0, rm};
  wire [31:0] quot = (mag == 17'h00000) ? `FPF_RCP_ONE : (`FPF_RCP_ONE / {15'h0000, mag});
  // reciprocal in q1.15; 1/1 cannot be shown and clips to max
  wire [15:0] rmag = (quot > {16'h0000, `FPF_RCP_MAX}) ? `FPF_RCP_MAX : quot[15:0];
  wire [15:0] rcp  = rm[15] ? (16'h0000 - rmag) : rmag;
  wire signed [31:0] dprod = $signed(rn) * $signed(rcp);

  wire [35:0] shift_left_load = {{20{rm[15]}}, rm} << fb;
  wire [35:0] shr = $signed(acc_q) >>> fb;
  wire        rbit = (fb == 4'h0) ? 1'b0 : acc_q[fb - 4'h1];
  wire [36:0] rnd = {shr[35], shr} + {36'h000000000, rbit};
  wire        rovf = ~((&rnd[36:15]) | ~(|rnd[36:15]));
  wire [15:0] rsat = rovf ? (rnd[36] ? 16'h8000 : 16'h7FFF) : rnd[15:0];

  // sequencer and flags
  reg  [35:0] acc_d;
  reg         sa_set, ss_set;
  always @* begin
    acc_d  = acc_q;
    sa_set = 1'b0;
    ss_set = 1'b0;
    if (done) begin
      case (op)
        `FPF_OP_MUL: acc_d = prod36;
        `FPF_OP_MAC: begin
          sa_set = movf;
          acc_d  = movf ? (msum[36] ? `FPF_SAT_NEG : `FPF_SAT_POS) : msum[35:0];
        end
        `FPF_OP_DIV: acc_d = {{4{dprod[31]}}, dprod};
        `FPF_OP_LSF: acc_d = shift_left_load;
        `FPF_OP_RSF: ss_set = rovf;
        default: acc_d = acc_q;
      endcase
    end
  end

  wire [7:0] trg_clr = (start & wt & hit) ? (8'h01 << wk) : 8'h00;
  wire [7:0] trg_set = ((c_cmt & ~c_idx[3]) ? (8'h01 << c_idx[2:0]) : 8'h00)
                     | (m_cmt ? (8'h01 << mov_addr) : 8'h00);
  wire       cw_ctrl = c_w & (cpu_addr == `FPF_A_CTRL);
  wire       cw_clr  = c_w & (cpu_addr == `FPF_A_CLR);
  wire       cw_dbg  = c_w & (cpu_addr == `FPF_A_DBG);
  wire       ev_done = done & ev;

  always @(posedge ref_clk or negedge rst_ni) begin
    if (!rst_ni) begin
      acc_q  <= 36'h000000000;
      pc_q   <= 5'h00;
      en_q   <= 1'b0;
      ie_q   <= 1'b0;
      ss_q   <= 1'b0;
      sa_q   <= 1'b0;
      evf_q  <= 1'b0;
      trg_q  <= 8'h00;
      mode_q <= 1'b0;
      stp_q  <= 1'b0;
      div_q  <= 4'h0;
      event0 <= 1'b0;
      event1 <= 1'b0;
    end else begin
      acc_q <= acc_d;
      if (c_w & (cpu_addr == `FPF_A_PC))
        pc_q <= cpu_wdata[4:0];
      else if (done)
        pc_q <= (op == `FPF_OP_JMP) ? ins[4:0] : pc_q + 5'h01;
      if (start & (op == `FPF_OP_DIV))
        div_q <= `FPF_DIV_CYC - 4'h1;
      else if (busy & ~stall)
        div_q <= div_q - 4'h1;
      if (cw_ctrl) begin
        en_q <= cpu_wdata[`FPF_B_EN];
        ie_q <= cpu_wdata[`FPF_B_IE];
      end
      // set beats a write-one clear in the same cycle
      ss_q  <= (ss_q  & ~(cw_ctrl & cpu_wdata[`FPF_B_SS]))  | ss_set;
      sa_q  <= (sa_q  & ~(cw_ctrl & cpu_wdata[`FPF_B_SA]))  | sa_set;
      evf_q <= (evf_q & ~(cw_ctrl & cpu_wdata[`FPF_B_EVF])) | ev_done;
      if (c_w & (cpu_addr == `FPF_A_TRIG))
        trg_q <= cpu_wdata | trg_set;
      else
        trg_q <= (trg_q & ~trg_clr) | trg_set;
      if (cw_dbg)
        mode_q <= cpu_wdata[`FPF_B_MODE];
      // old mode value gates the pulse, so setting both at once never steps
      if (cw_dbg & cpu_wdata[`FPF_B_STEP] & mode_q)
        stp_q <= 1'b1;
      else if (start | ~mode_q)
        stp_q <= 1'b0;
      event0 <= ev_done & (wk != 3'h7);
      event1 <= ev_done & (wk == 3'h7);
    end
  end
  assign irq = evf_q & ie_q;

  // register file: external commits, then sequencer stores
  always @(posedge ref_clk or negedge rst_ni) begin
    if (!rst_ni) begin
      for (i = 0; i < 16; i = i + 1)
        rf_q[i] <= 16'h0000;
    end else begin
      if (c_cmt)
        rf_q[c_idx] <= {cpu_wdata, c_tmp};
      if (m_cmt)
        rf_q[m_idx] <= {mov_wdata, mv_tmp_q};
      if (done & (op == `FPF_OP_RSF))
        rf_q[fa] <= rsat;
      if (done & (op == `FPF_OP_MVC)) begin
        for (i = 1; i < 16; i = i + 1)
          if ((i > fb) && (i <= fa))
            rf_q[i] <= rf_q[i - 1];
      end
    end
  end

  // access counters and half holding registers
  always @(posedge ref_clk or negedge rst_ni) begin
    if (!rst_ni) begin
      cs_cnt_q <= 1'b0;
      cx_cnt_q <= 1'b0;
      mv_cnt_q <= 1'b0;
      cs_tmp_q <= 8'h00;
      cx_tmp_q <= 8'h00;
      mv_tmp_q <= 8'h00;
    end else begin
      if ((cpu_wr | cpu_rd) & c_rf) begin
        if (c_idx[3])
          cx_cnt_q <= ~cx_cnt_q;
        else
          cs_cnt_q <= ~cs_cnt_q;
        if (~c_cnt) begin
          if (c_idx[3])
            cx_tmp_q <= cpu_wr ? cpu_wdata : rf_q[c_idx][15:8];
          else
            cs_tmp_q <= cpu_wr ? cpu_wdata : rf_q[c_idx][15:8];
        end
      end
      if (cw_clr & cpu_wdata[`FPF_B_CCLR]) begin
        cs_cnt_q <= 1'b0;
        cx_cnt_q <= 1'b0;
      end
      if (mov_wr | mov_rd) begin
        mv_cnt_q <= ~mv_cnt_q;
        if (~mv_cnt_q)
          mv_tmp_q <= mov_wr ? mov_wdata : rf_q[m_idx][15:8];
      end
      if (cw_clr & cpu_wdata[`FPF_B_MCLR])
        mv_cnt_q <= 1'b0;
    end
  end

  // instruction store, low byte held until high byte commits
  always @(posedge ref_clk or negedge rst_ni) begin
    if (!rst_ni) begin
      padr_q <= 5'h00;
      plo_q  <= 8'h00;
    end else begin
      if (c_w & (cpu_addr == `FPF_A_PRGA))
        padr_q <= cpu_wdata[4:0];
      if (c_w & (cpu_addr == `FPF_A_PRGL))
        plo_q <= cpu_wdata;
    end
  end
  always @(posedge ref_clk) begin
    if (c_w & (cpu_addr == `FPF_A_PRGH))
      prog_q[padr_q] <= {cpu_wdata, plo_q};
  end

  // read ports
  reg [7:0] c_rd;
  always @* begin
    c_rd = 8'h00;
    if (c_rf)
      c_rd = c_cnt ? c_tmp : rf_q[c_idx][7:0];
    else if (c_acc)
      c_rd = (cpu_addr == `FPF_A_ACC4) ? {4'h0, acc_q[35:32]}
                                        : acc_q[{cpu_addr[1:0], 3'b000} +: 8];
    else begin
      case (cpu_addr)
        `FPF_A_CTRL: c_rd = {en_q, ie_q, 3'b000, ss_q, sa_q, evf_q};
        `FPF_A_PC:   c_rd = {3'b000, pc_q};
        `FPF_A_TRIG: c_rd = trg_q;
        `FPF_A_DBG:  c_rd = {mode_q, 7'h00};
        `FPF_A_PRGL: c_rd = prog_q[padr_q][7:0];
        `FPF_A_PRGH: c_rd = prog_q[padr_q][15:8];
        `FPF_A_PRGA: c_rd = {3'b000, padr_q};
        default:     c_rd = 8'h00;
      endcase
    end
  end
  always @(posedge ref_clk or negedge rst_ni) begin
    if (!rst_ni) begin
      cpu_rdata <= 8'h00;
      mov_rdata <= 8'h00;
    end else begin
      cpu_rdata <= cpu_rd ? c_rd : 8'h00;
      mov_rdata <= mov_rd ? (mv_cnt_q ? mv_tmp_q : rf_q[m_idx][7:0]) : 8'h00;
    end
  end
endmodule // fpf_top
`default_nettype wire

// File: tb/fpf_monitor.sv
// port checker for the filter sequencer
`timescale 1ns/1ps
`default_nettype none
module fpf_monitor (
  input wire logic       ref_clk,   // clock
  input wire logic       rst_n,     // reset, low
  input wire logic [7:0] cpu_addr,  // cpu address
  input wire logic       cpu_wr,    // cpu write
  input wire logic       cpu_rd,    // cpu read
  input wire logic [7:0] cpu_rdata, // cpu read data
  input wire logic       mov_wr,    // mover write
  input wire logic       mov_rd,    // mover read
  input wire logic [7:0] mov_rdata, // mover read data
  input wire logic       event0,    // event 0
  input wire logic       event1,    // event 1
  input wire logic       irq        // interrupt
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  wire any_stb = cpu_wr | cpu_rd | mov_wr | mov_rd;
  AST_EV_ONEHOT: assert property (!(event0 && event1))
    else $error("both event outputs high");
  AST_CPU_IDLE: assert property (!cpu_rd |=> cpu_rdata == 8'h00)
    else $error("cpu read data without read");
  AST_MOV_IDLE: assert property (!mov_rd |=> mov_rdata == 8'h00)
    else $error("mover read data without read");
  AST_IRQ_RISE: assert property ($rose(irq) |-> event0 || event1 || $past(cpu_wr))
    else $error("irq rose without event or write");
  AST_IRQ_HOLD: assert property (irq && !cpu_wr |=> irq)
    else $error("irq dropped without software write");
  AST_EV_STALL: assert property (event0 || event1 |-> !$past(any_stb))
    else $error("instruction completed in a strobe cycle");
  AST_CLR_RD0: assert property (cpu_rd && cpu_addr == 8'h03 |=> cpu_rdata == 8'h00)
    else $error("counter clear read not zero");
  AST_STEP_RD0: assert property (cpu_rd && cpu_addr == 8'h04 |=> !cpu_rdata[6])
    else $error("step pulse read not zero");
endmodule // fpf_monitor
bind fpf_top fpf_monitor u_fpf_monitor (.ref_clk(ref_clk), .rst_n(rst_n), .cpu_addr(cpu_addr),
  .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata), .mov_wr(mov_wr), .mov_rd(mov_rd),
  .mov_rdata(mov_rdata), .event0(event0), .event1(event1), .irq(irq));
`default_nettype wire

// File: tb/fpf_mover_model.sv
// register transfer engine model on the mover port
`timescale 1ns/1ps
`default_nettype none
module fpf_mover_model (
  input  wire logic       ref_clk,   // clock
  output var  logic [2:0] mov_addr,  // register select
  output var  logic [7:0] mov_wdata, // write data
  output var  logic       mov_wr,    // write strobe
  output var  logic       mov_rd,    // read strobe
  input  wire logic [7:0] mov_rdata  // read data
);
  initial begin
    mov_addr = 3'h0;
    mov_wdata = 8'hA5;
    mov_wr = 1'b0;
    mov_rd = 1'b0;
  end
  // released data inverted so a stale byte is never taken for fresh
  task put(input logic [2:0] r, input logic [7:0] d);
    @(posedge ref_clk);
    mov_addr <= r;
    mov_wdata <= d;
    mov_wr <= 1'b1;
    @(posedge ref_clk);
    mov_wr <= 1'b0;
    mov_wdata <= ~d;
  endtask
  task get(input logic [2:0] r, output logic [7:0] d);
    @(posedge ref_clk);
    mov_addr <= r;
    mov_rd <= 1'b1;
    @(posedge ref_clk);
    mov_rd <= 1'b0;
    #1 d = mov_rdata;
  endtask
  task wr16(input logic [2:0] r, input logic [15:0] v);
    put(r, v[7:0]);
    put(r, v[15:8]);
  endtask
  task rd16(input logic [2:0] r, output logic [15:0] v);
    get(r, v[7:0]);
    get(r, v[15:8]);
  endtask
endmodule // fpf_mover_model
`default_nettype wire

// File: tb/fpf_top_tb.sv
// self-checking bench for the filter sequencer
`timescale 1ns/1ps
`default_nettype none
module fpf_top_tb;
  logic        ref_clk, rst_n, cpu_wr, cpu_rd, mov_wr, mov_rd, event0, event1, irq;
  logic  [7:0] cpu_addr, cpu_wdata, cpu_rdata, mov_wdata, mov_rdata, b;
  logic  [2:0] mov_addr;
  logic [15:0] v;
  logic [39:0] acc;
  int          num_errors, n_tests, n_ev0, n_ev1;
  logic [15:0] prog [8] = '{16'h0212, 16'h0312, 16'h0634, 16'h0764,
                            16'h0745, 16'h8800, 16'h7800, 16'h0105};
  fpf_top u_fpf_top (.ref_clk, .rst_n, .cpu_addr, .cpu_wdata, .cpu_wr, .cpu_rd, .cpu_rdata,
    .mov_addr, .mov_wdata, .mov_wr, .mov_rd, .mov_rdata, .event0, .event1, .irq);
  fpf_mover_model u_fpf_mover_model (.ref_clk, .mov_addr, .mov_wdata, .mov_wr, .mov_rd,
    .mov_rdata);
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (event0 === 1'b1) n_ev0 <= n_ev0 + 1;
    if (event1 === 1'b1) n_ev1 <= n_ev1 + 1;
  end
  task give_verdict;
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input string n, input logic [35:0] e, input logic [35:0] g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task cw(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    cpu_addr <= a;
    cpu_wdata <= d;
    cpu_wr <= 1'b1;
    @(posedge ref_clk);
    cpu_wr <= 1'b0;
  endtask
  task cr(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    cpu_addr <= a;
    cpu_rd <= 1'b1;
    @(posedge ref_clk);
    cpu_rd <= 1'b0;
    #1 d = cpu_rdata;
  endtask
  task w16(input logic [3:0] r, input logic [15:0] d);
    cw({4'h1, r}, d[7:0]);
    cw({4'h1, r}, d[15:8]);
  endtask
  task r16(input logic [3:0] r, output logic [15:0] d);
    cr({4'h1, r}, d[7:0]);
    cr({4'h1, r}, d[15:8]);
  endtask
  task pw(input logic [4:0] a, input logic [15:0] w);
    cw(8'h2A, {3'h0, a});
    cw(8'h28, w[7:0]);
    cw(8'h29, w[15:8]);
  endtask
  initial begin
    repeat (5000) @(posedge ref_clk);
    num_errors++;
    give_verdict;
  end
  initial begin
    {rst_n, cpu_wr, cpu_rd, cpu_addr, cpu_wdata} = '0;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    cr(8'h00, b); chk("ctrl", 8'h00, b);
    for (int i = 0; i < 8; i++) pw(5'(i), prog[i]);
    pw(5'h1F, 16'h7800);
    cw(8'h2A, 8'h07);
    cr(8'h28, b); chk("prog lo", 8'h05, b);
    cr(8'h29, b); chk("prog hi", 8'h01, b);
    w16(4'h1, 16'h8000);
    w16(4'h2, 16'h7FFF);
    w16(4'h6, 16'h3333);
    cw(8'h14, 8'h11);
    cw(8'h03, 8'h02);
    w16(4'h4, 16'h1111);
    u_fpf_mover_model.put(3'h5, 8'h22);
    cw(8'h03, 8'h01);
    u_fpf_mover_model.wr16(3'h5, 16'h2222);
    cr(8'h03, b); chk("clr", 8'h00, b);
    r16(4'h1, v); chk("r1", 16'h8000, v);
    cw(8'h00, 8'hC0);
    repeat (20) @(posedge ref_clk);
    acc = 40'h0F80010000;
    for (int i = 0; i < 5; i++) begin
      cr(8'h20 + 8'(i), b); chk("acc", acc[i*8 +: 8], b);
    end
    r16(4'h3, v); chk("rsf", 16'h8000, v);
    cr(8'h00, b); chk("sat", 8'hC4, b);
    cw(8'h00, 8'hC4);
    cr(8'h00, b); chk("sat clr", 8'hC0, b);
    r16(4'h6, v); chk("r6", 16'h2222, v);
    r16(4'h4, v); chk("r4", 16'h1111, v);
    u_fpf_mover_model.rd16(3'h5, v); chk("r5", 16'h1111, v);
    chk("wait", 0, n_ev0);
    u_fpf_mover_model.wr16(3'h0, 16'h0001);
    repeat (10) @(posedge ref_clk);
    chk("ev0", 1, n_ev0);
    chk("ev1", 1, n_ev1);
    chk("irq", 1, irq);
    cw(8'h00, 8'hC1);
    #1 chk("irq clr", 0, irq);
    cw(8'h00, 8'h40);
    u_fpf_mover_model.wr16(3'h0, 16'h0002);
    cr(8'h02, b); chk("trig", 8'h77, b);
    cw(8'h00, 8'hC0);
    repeat (10) @(posedge ref_clk);
    chk("pre set", 2, n_ev0);
    cr(8'h02, b); chk("trig clr", 8'h76, b);
    cw(8'h04, 8'hC0);
    repeat (5) @(posedge ref_clk);
    chk("no step", 2, n_ev0);
    cr(8'h04, b); chk("dbg", 8'h80, b);
    cw(8'h04, 8'hC0);
    repeat (5) @(posedge ref_clk);
    chk("step", 3, n_ev0);
    chk("one step", 2, n_ev1);
    cw(8'h01, 8'h1F);
    cw(8'h04, 8'hC0);
    repeat (5) @(posedge ref_clk);
    chk("last", 3, n_ev1);
    cr(8'h01, b); chk("wrap", 8'h00, b);
    pw(5'h08, 16'h0412);
    pw(5'h09, 16'h0523);
    cw(8'h01, 8'h08);
    cw(8'h04, 8'hC0);
    repeat (15) @(posedge ref_clk);
    acc = 40'h0FFFFF8001;
    for (int i = 0; i < 5; i++) begin
      cr(8'h20 + 8'(i), b); chk("div", acc[i*8 +: 8], b);
    end
    cr(8'h01, b); chk("div pc", 8'h09, b);
    cw(8'h04, 8'hC0);
    repeat (5) @(posedge ref_clk);
    acc = 40'h000003FFF8;
    for (int i = 0; i < 5; i++) begin
      cr(8'h20 + 8'(i), b); chk("lsf", acc[i*8 +: 8], b);
    end
    give_verdict;
  end
endmodule // fpf_top_tb
`default_nettype wire
